// *** src/dout_sel_pkg.sv ***
// Purpose: constants and carriers for the digital output function selector
// Assumes: one 20 MHz clock, asynchronous active-low reset
// Notes:   selector codes and parameter addresses shared by design and bench
//
// Functional notes
// R1 - code 1 leaves the output free, driven by its general-use level only
// R2 - code 2 asserts output in ready-to-switch-on, switched-on or operation-enabled
// R3 - code 3 asserts output only in operation-enabled state
// R4 - code 4 asserts output while capture-triggered relative move is active or finished
// R5 - code 5 shows position deviation in window; code 6 velocity deviation in window
// R6 - code 7 shows velocity below threshold; code 8 current below threshold
// R7 - code 9 drives the output with halt acknowledgement
// R8 - code 13 asserts output while motor is at standstill
// R9 - code 14 asserts output while a selected class 1 to 4 error is active
// R10 - code 16 asserts output while a selected class 0 warning is active
// R11 - code 22 shows positive motion; code 23 shows negative motion
// R12 - selector writes accepted only with power stage disabled; operator disables it first
// R13 - written selector is stored but governs the output only after next power-on
// R14 - writes of unlisted codes are rejected and the old value kept
package dout_sel_pkg;

  // parameter addresses on the fieldbus
  localparam logic [15:0] ADDR_OUT2 = 16'h0716;
  localparam logic [15:0] ADDR_OUT3 = 16'h0718;

  // selector codes
  localparam logic [15:0] SEL_FREE     = 16'h0001;
  localparam logic [15:0] SEL_NO_FAULT = 16'h0002;
  localparam logic [15:0] SEL_ACTIVE   = 16'h0003;
  localparam logic [15:0] SEL_REL_MOVE = 16'h0004;
  localparam logic [15:0] SEL_POS_WIN  = 16'h0005;
  localparam logic [15:0] SEL_VEL_WIN  = 16'h0006;
  localparam logic [15:0] SEL_VEL_LOW  = 16'h0007;
  localparam logic [15:0] SEL_CUR_LOW  = 16'h0008;
  localparam logic [15:0] SEL_HALT_ACK = 16'h0009;
  localparam logic [15:0] SEL_STILL    = 16'h000D;
  localparam logic [15:0] SEL_ERROR    = 16'h000E;
  localparam logic [15:0] SEL_WARNING  = 16'h0010;
  localparam logic [15:0] SEL_MOVE_POS = 16'h0016;
  localparam logic [15:0] SEL_MOVE_NEG = 16'h0017;

  // value of both selectors after reset
  localparam logic [15:0] SEL_RESET    = SEL_FREE;

  localparam int unsigned NUM_OUTPUTS = 2;

  // internal status conditions feeding the outputs
  typedef struct packed {
    logic ready_to_switch_on;
    logic switched_on;
    logic operation_enabled;
    logic relative_move_after_capture;
    logic pos_dev_in_window;
    logic vel_dev_in_window;
    logic vel_below_threshold;
    logic cur_below_threshold;
    logic halt_ack;
    logic standstill;
    logic selected_error;
    logic selected_warning;
    logic moves_positive;
    logic moves_negative;
  } status_s;

  // one parameter access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } param_req_s;

endpackage

// *** src/digital_output_function_select.sv ***
// Purpose: selects the status condition driven onto digital outputs 2 and 3
// Assumes: status and requests come from logic on clk; no synchronisers needed
// Notes:   stored selector is the persistent copy; active selector is what drives
module digital_output_function_select (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // parameter access
  input  wire dout_sel_pkg::param_req_s param_req,
  output logic [15:0]                   param_rdata,
  output logic                          param_ack,
  output logic                          param_err,
  // drive state
  input  wire logic                     power_stage_enabled,
  input  wire logic                     power_up_load,
  input  wire dout_sel_pkg::status_s    status,
  input  wire logic [1:0]               free_level,
  // outputs
  output logic                          digital_output_2,
  output logic                          digital_output_3
);

  logic [1:0][15:0] stored_r;
  logic [1:0][15:0] active_r;
  logic [1:0]       out_r;
  logic [15:0]      rdata_r;
  logic             ack_r;
  logic             err_r;
  logic             hit;
  logic             idx;
  logic             wr_ok;
  logic             rd_ok;

  function automatic logic sel_valid(input logic [15:0] c);
    logic v;
    v = 1'b0;
    case (c)
      dout_sel_pkg::SEL_FREE, dout_sel_pkg::SEL_NO_FAULT, dout_sel_pkg::SEL_ACTIVE,
      dout_sel_pkg::SEL_REL_MOVE, dout_sel_pkg::SEL_POS_WIN, dout_sel_pkg::SEL_VEL_WIN,
      dout_sel_pkg::SEL_VEL_LOW, dout_sel_pkg::SEL_CUR_LOW, dout_sel_pkg::SEL_HALT_ACK,
      dout_sel_pkg::SEL_STILL, dout_sel_pkg::SEL_ERROR, dout_sel_pkg::SEL_WARNING,
      dout_sel_pkg::SEL_MOVE_POS, dout_sel_pkg::SEL_MOVE_NEG: v = 1'b1;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  function automatic logic sel_drive(input logic [15:0] c, input dout_sel_pkg::status_s s,
                                     input logic free);
    logic d;
    d = 1'b0;
    case (c)
      dout_sel_pkg::SEL_FREE:     d = free;                                // [R1]
      dout_sel_pkg::SEL_NO_FAULT: d = s.ready_to_switch_on | s.switched_on
                                      | s.operation_enabled;               // [R2]
      dout_sel_pkg::SEL_ACTIVE:   d = s.operation_enabled;                 // [R3]
      dout_sel_pkg::SEL_REL_MOVE: d = s.relative_move_after_capture;       // [R4]
      dout_sel_pkg::SEL_POS_WIN:  d = s.pos_dev_in_window;                 // [R5]
      dout_sel_pkg::SEL_VEL_WIN:  d = s.vel_dev_in_window;                 // [R5]
      dout_sel_pkg::SEL_VEL_LOW:  d = s.vel_below_threshold;               // [R6]
      dout_sel_pkg::SEL_CUR_LOW:  d = s.cur_below_threshold;               // [R6]
      dout_sel_pkg::SEL_HALT_ACK: d = s.halt_ack;                          // [R7]
      dout_sel_pkg::SEL_STILL:    d = s.standstill;                        // [R8]
      dout_sel_pkg::SEL_ERROR:    d = s.selected_error;                    // [R9]
      dout_sel_pkg::SEL_WARNING:  d = s.selected_warning;                  // [R10]
      dout_sel_pkg::SEL_MOVE_POS: d = s.moves_positive;                    // [R11]
      dout_sel_pkg::SEL_MOVE_NEG: d = s.moves_negative;                    // [R11]
      default:                    d = 1'b0;
    endcase
    return d;
  endfunction

  // address decode
  always_comb begin
    hit = 1'b0;
    idx = 1'b0;
    if (param_req.addr == dout_sel_pkg::ADDR_OUT2) begin
      hit = 1'b1;
      idx = 1'b0;
    end else if (param_req.addr == dout_sel_pkg::ADDR_OUT3) begin
      hit = 1'b1;
      idx = 1'b1;
    end
  end

  // a write wins over a simultaneous read
  assign wr_ok = param_req.wr & hit & ~power_stage_enabled
                 & sel_valid(param_req.wdata);                             // [R12] [R14]
  assign rd_ok = param_req.rd & ~param_req.wr & hit;

  genvar g;
  generate
    for (g = 0; g < dout_sel_pkg::NUM_OUTPUTS; g++) begin : gen_out
      // persistent copy, updated by accepted writes
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stored_r[g] <= dout_sel_pkg::SEL_RESET;
        end else if (wr_ok && (idx == 1'(g))) begin
          stored_r[g] <= param_req.wdata;                                  // [R13]
        end
      end

      // new setting only takes hold at power-on, so a running output never glitches
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          active_r[g] <= dout_sel_pkg::SEL_RESET;
        end else if (power_up_load) begin
          active_r[g] <= stored_r[g];                                      // [R13]
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          out_r[g] <= 1'b0;
        end else begin
          out_r[g] <= sel_drive(active_r[g], status, free_level[g]);
        end
      end
    end
  endgenerate

  // access answer, one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      ack_r <= wr_ok | rd_ok;
      err_r <= (param_req.wr & ~wr_ok) | (param_req.rd & ~param_req.wr & ~hit); // [R12] [R14]
    end
  end

  // read data holds until the next good read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else if (rd_ok) begin
      rdata_r <= stored_r[idx];
    end
  end

  assign param_rdata      = rdata_r;
  assign param_ack        = ack_r;
  assign param_err        = err_r;
  assign digital_output_2 = out_r[0];
  assign digital_output_3 = out_r[1];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_out2;
    param_req.wr && param_req.addr == dout_sel_pkg::ADDR_OUT2;
  endsequence

  sequence s_blocked_write;
    s_write_out2 ##0 (power_stage_enabled || !sel_valid(param_req.wdata));
  endsequence

  a_blocked_write_kept: assert property (                                  // [R12]
    s_blocked_write |=> ($stable(stored_r[0]) && param_err && !param_ack))
    else $error("selector changed by a refused write");

  a_invalid_code_err: assert property (                                    // [R14]
    (s_write_out2 ##0 !sel_valid(param_req.wdata)) |=> param_err ##0 $stable(stored_r[0]))
    else $error("invalid selector code was not refused");

  a_good_write_stored: assert property (                                   // [R13]
    (s_write_out2 ##0 (!power_stage_enabled && sel_valid(param_req.wdata)))
      |=> (stored_r[0] == $past(param_req.wdata) && param_ack))
    else $error("accepted write not stored");

  a_active_needs_load: assert property (                                   // [R13]
    !power_up_load |=> $stable(active_r))
    else $error("active selector changed without power-on");

  a_load_copies_stored: assert property (                                  // [R13]
    power_up_load |=> (active_r == $past(stored_r)))
    else $error("power-on load did not copy stored selector");

  a_free_level_out: assert property (                                      // [R1]
    active_r[0] == dout_sel_pkg::SEL_FREE |=> digital_output_2 == $past(free_level[0]))
    else $error("free output not following its level");

  a_no_fault_out: assert property (                                        // [R2]
    active_r[1] == dout_sel_pkg::SEL_NO_FAULT |=> digital_output_3 ==
      $past(status.ready_to_switch_on | status.switched_on | status.operation_enabled))
    else $error("no-fault output wrong");

  a_active_out: assert property (                                          // [R3]
    active_r[0] == dout_sel_pkg::SEL_ACTIVE |=>
      digital_output_2 == $past(status.operation_enabled))
    else $error("operation-enabled output wrong");

  a_rel_move_out: assert property (                                        // [R4]
    active_r[0] == dout_sel_pkg::SEL_REL_MOVE |=>
      digital_output_2 == $past(status.relative_move_after_capture))
    else $error("capture move output wrong");

  a_window_out: assert property (                                          // [R5]
    active_r[0] == dout_sel_pkg::SEL_VEL_WIN |=>
      digital_output_2 == $past(status.vel_dev_in_window))
    else $error("velocity window output wrong");

  a_threshold_out: assert property (                                       // [R6]
    active_r[1] == dout_sel_pkg::SEL_CUR_LOW |=>
      digital_output_3 == $past(status.cur_below_threshold))
    else $error("current threshold output wrong");

  a_halt_ack_out: assert property (                                        // [R7]
    active_r[0] == dout_sel_pkg::SEL_HALT_ACK |=> digital_output_2 == $past(status.halt_ack))
    else $error("halt acknowledge output wrong");

  a_standstill_out: assert property (                                      // [R8]
    active_r[1] == dout_sel_pkg::SEL_STILL |=> digital_output_3 == $past(status.standstill))
    else $error("standstill output wrong");

  a_error_out: assert property (                                           // [R9]
    active_r[0] == dout_sel_pkg::SEL_ERROR |=>
      digital_output_2 == $past(status.selected_error))
    else $error("selected error output wrong");

  a_warning_out: assert property (                                         // [R10]
    active_r[1] == dout_sel_pkg::SEL_WARNING |=>
      digital_output_3 == $past(status.selected_warning))
    else $error("selected warning output wrong");

  a_direction_out: assert property (                                       // [R11]
    active_r[0] == dout_sel_pkg::SEL_MOVE_NEG |=>
      digital_output_2 == $past(status.moves_negative))
    else $error("negative direction output wrong");

  // output 3 gets its own write checks, the refusal path must not leak across
  sequence s_write_out3;
    param_req.wr && param_req.addr == dout_sel_pkg::ADDR_OUT3;
  endsequence

  a_blocked_out3_kept: assert property (                                   // [R12]
    (s_write_out3 ##0 (power_stage_enabled || !sel_valid(param_req.wdata)))
      |=> ($stable(stored_r[1]) && param_err && !param_ack))
    else $error("output 3 selector changed by a refused write");

  a_good_out3_stored: assert property (                                    // [R13]
    (s_write_out3 ##0 (!power_stage_enabled && sel_valid(param_req.wdata)))
      |=> (stored_r[1] == $past(param_req.wdata) && param_ack))
    else $error("accepted output 3 write not stored");

  a_read_returns_stored: assert property (                                 // [R13]
    (param_req.rd && !param_req.wr && param_req.addr == dout_sel_pkg::ADDR_OUT3)
      |=> (param_rdata == $past(stored_r[1]) && param_ack))
    else $error("read did not return stored selector");

  a_ack_err_apart: assert property (                                       // [R14]
    !(param_ack && param_err))
    else $error("request both accepted and refused");

  a_free_level_out3: assert property (                                     // [R1]
    active_r[1] == dout_sel_pkg::SEL_FREE |=> digital_output_3 == $past(free_level[1]))
    else $error("output 3 free level not followed");

  a_no_fault_out2: assert property (                                       // [R2]
    active_r[0] == dout_sel_pkg::SEL_NO_FAULT |=> digital_output_2 ==
      $past(status.ready_to_switch_on | status.switched_on | status.operation_enabled))
    else $error("output 2 no-fault level wrong");

  a_active_out3: assert property (                                         // [R3]
    active_r[1] == dout_sel_pkg::SEL_ACTIVE |=>
      digital_output_3 == $past(status.operation_enabled))
    else $error("output 3 operation-enabled level wrong");

  a_rel_move_out3: assert property (                                       // [R4]
    active_r[1] == dout_sel_pkg::SEL_REL_MOVE |=>
      digital_output_3 == $past(status.relative_move_after_capture))
    else $error("output 3 capture move level wrong");

  a_pos_window_out: assert property (                                      // [R5]
    active_r[1] == dout_sel_pkg::SEL_POS_WIN |=>
      digital_output_3 == $past(status.pos_dev_in_window))
    else $error("position window output wrong");

  a_vel_low_out: assert property (                                         // [R6]
    active_r[0] == dout_sel_pkg::SEL_VEL_LOW |=>
      digital_output_2 == $past(status.vel_below_threshold))
    else $error("velocity threshold output wrong");

  a_halt_ack_out3: assert property (                                       // [R7]
    active_r[1] == dout_sel_pkg::SEL_HALT_ACK |=>
      digital_output_3 == $past(status.halt_ack))
    else $error("output 3 halt acknowledge level wrong");

  a_standstill_out2: assert property (                                     // [R8]
    active_r[0] == dout_sel_pkg::SEL_STILL |=>
      digital_output_2 == $past(status.standstill))
    else $error("output 2 standstill level wrong");

  a_error_out3: assert property (                                          // [R9]
    active_r[1] == dout_sel_pkg::SEL_ERROR |=>
      digital_output_3 == $past(status.selected_error))
    else $error("output 3 selected error level wrong");

  a_warning_out2: assert property (                                        // [R10]
    active_r[0] == dout_sel_pkg::SEL_WARNING |=>
      digital_output_2 == $past(status.selected_warning))
    else $error("output 2 selected warning level wrong");

  a_positive_out: assert property (                                        // [R11]
    active_r[1] == dout_sel_pkg::SEL_MOVE_POS |=>
      digital_output_3 == $past(status.moves_positive))
    else $error("positive direction output wrong");

endmodule

// *** verification/output_load.sv ***
// Purpose: field-side load wired to digital outputs 2 and 3
// Assumes: outputs are push-pull, always driven, so no pull level is needed
// Notes:   sees the pins as external equipment would, no filtering
module output_load (
  // pins from the drive
  input  wire logic       digital_output_2,
  input  wire logic       digital_output_3,
  // observed levels, bit0 = output 2
  output logic      [1:0] seen
);
  timeunit 1ns;
  timeprecision 1ns;
  assign seen = {digital_output_3, digital_output_2};
endmodule

// *** verification/digital_output_function_select_tb.sv ***
// Purpose: self-checking bench for the digital output function selector
// Assumes: inputs change on the falling edge, results sampled there too
// Notes:   no long counts, so the run needs only about 410 cycles
module digital_output_function_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     clk;
  logic                     rst_n;
  dout_sel_pkg::param_req_s req;
  logic [15:0]              param_rdata;
  logic                     param_ack;
  logic                     param_err;
  logic                     pse;
  logic                     pul;
  dout_sel_pkg::status_s    st;
  logic [1:0]               fl;
  logic                     do2;
  logic                     do3;
  logic [1:0]               seen;
  logic [15:0]              act2;
  logic [15:0]              act3;
  int                       error_cnt;
  int                       checked;
  int                       cycles;
  logic [15:0] codes [14] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006,
    16'h0007, 16'h0008, 16'h0009, 16'h000D, 16'h000E, 16'h0010, 16'h0016, 16'h0017};
  logic [15:0] bad [4] = '{16'h0000, 16'h000A, 16'h000F, 16'h0018};

  digital_output_function_select dut (.clk(clk), .rst_n(rst_n), .param_req(req),
    .param_rdata(param_rdata), .param_ack(param_ack), .param_err(param_err),
    .power_stage_enabled(pse), .power_up_load(pul), .status(st), .free_level(fl),
    .digital_output_2(do2), .digital_output_3(do3));
  output_load load (.digital_output_2(do2), .digital_output_3(do3), .seen(seen));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict();
    $display("errors %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard, far above the roughly 410 cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic [1:0] got, input logic [1:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one request, answer looked at in the single cycle it stands
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic [1:0] exp_ae);
    @(negedge clk);
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    req = '0;
    chk_b({param_ack, param_err}, exp_ae);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000, 2'b10);
    chk_w(param_rdata, exp);
  endtask

  function automatic logic f(input logic [15:0] c, input dout_sel_pkg::status_s s,
                             input logic fr);
    case (c)
      16'h0001: return fr;
      16'h0002: return s.ready_to_switch_on | s.switched_on | s.operation_enabled;
      16'h0003: return s.operation_enabled;
      16'h0004: return s.relative_move_after_capture;
      16'h0005: return s.pos_dev_in_window;
      16'h0006: return s.vel_dev_in_window;
      16'h0007: return s.vel_below_threshold;
      16'h0008: return s.cur_below_threshold;
      16'h0009: return s.halt_ack;
      16'h000D: return s.standstill;
      16'h000E: return s.selected_error;
      16'h0010: return s.selected_warning;
      16'h0016: return s.moves_positive;
      16'h0017: return s.moves_negative;
      default:  return 1'b0;
    endcase
  endfunction

  task automatic out_chk();
    chk_b(seen, {f(act3, st, fl[1]), f(act2, st, fl[0])});
  endtask

  initial begin
    rst_n = 1'b0;
    req = '0;
    pse = 1'b0;
    pul = 1'b0;
    st = '0;
    fl = 2'b10;
    act2 = dout_sel_pkg::SEL_RESET;
    act3 = dout_sel_pkg::SEL_RESET;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    rd_chk(dout_sel_pkg::ADDR_OUT2, dout_sel_pkg::SEL_RESET);
    rd_chk(dout_sel_pkg::ADDR_OUT3, dout_sel_pkg::SEL_RESET);
    out_chk();
    acc(1'b1, 16'h0717, dout_sel_pkg::SEL_ACTIVE, 2'b01);
    acc(1'b0, 16'h0700, 16'h0000, 2'b01);
    foreach (bad[i]) begin
      acc(1'b1, dout_sel_pkg::ADDR_OUT2, bad[i], 2'b01);
    end
    rd_chk(dout_sel_pkg::ADDR_OUT2, dout_sel_pkg::SEL_FREE);
    @(negedge clk);
    pse = 1'b1;
    acc(1'b1, dout_sel_pkg::ADDR_OUT3, dout_sel_pkg::SEL_ACTIVE, 2'b01);
    acc(1'b1, dout_sel_pkg::ADDR_OUT2, dout_sel_pkg::SEL_STILL, 2'b01);
    pse = 1'b0;
    rd_chk(dout_sel_pkg::ADDR_OUT3, dout_sel_pkg::SEL_FREE);
    rd_chk(dout_sel_pkg::ADDR_OUT2, dout_sel_pkg::SEL_FREE);
    for (int i = 0; i < 14; i++) begin
      acc(1'b1, dout_sel_pkg::ADDR_OUT2, codes[i], 2'b10);
      acc(1'b1, dout_sel_pkg::ADDR_OUT3, codes[(i + 5) % 14], 2'b10);
      rd_chk(dout_sel_pkg::ADDR_OUT2, codes[i]);
      rd_chk(dout_sel_pkg::ADDR_OUT3, codes[(i + 5) % 14]);
      st = dout_sel_pkg::status_s'(14'h2AAA + 14'(i));
      fl = 2'b01;
      @(negedge clk);
      out_chk();
      pul = 1'b1;
      @(negedge clk);
      pul = 1'b0;
      repeat (2) @(negedge clk);
      act2 = codes[i];
      act3 = codes[(i + 5) % 14];
      for (int b = 0; b < 15; b++) begin
        st = dout_sel_pkg::status_s'((b < 14) ? (14'h1 << b) : 14'h0);
        fl = 2'(b);
        @(negedge clk);
        out_chk();
      end
    end
    give_verdict();
  end
endmodule
